/* rtl/adm_pkg.sv */
// Package: control word layout, register indices, reset values, timing
package adm_pkg;

    // Control word layout
    localparam int WORD_W = 16;
    localparam int WORD_ZERO_BIT = 15;
    localparam int IDX_MSB = 14;
    localparam int IDX_LSB = 8;
    localparam int DATA_MSB = 7;

    // Register indices
    localparam logic [6:0] IDX_ATT_LEFT = 7'h10;
    localparam logic [6:0] IDX_ATT_RIGHT = 7'h11;
    localparam logic [6:0] IDX_MUTE_RATE = 7'h12;
    localparam logic [6:0] IDX_CHAN_DEEMPH = 7'h13;
    localparam logic [6:0] IDX_FORMAT = 7'h14;
    localparam logic [6:0] IDX_PHASE_FLAG = 7'h16;

    // Field positions
    localparam int POS_LEFT_MUTE = 0;
    localparam int POS_RIGHT_MUTE = 1;
    localparam int POS_OVS = 6;
    localparam int POS_SOFT_REINIT = 7;
    localparam int POS_LEFT_DIS = 0;
    localparam int POS_RIGHT_DIS = 1;
    localparam int POS_DEEMPH_EN = 4;
    localparam int POS_DEEMPH_RATE = 5;
    localparam int POS_FORMAT = 0;
    localparam int POS_ROLLOFF = 5;
    localparam int POS_INVERT = 0;
    localparam int POS_FLAG_POL = 1;
    localparam int POS_FLAG_COMB = 2;

    // Writable bits of each register; reserved bits hold zero
    localparam logic [7:0] MASK_MUTE_RATE = 8'h43;
    localparam logic [7:0] MASK_CHAN_DEEMPH = 8'h73;
    localparam logic [7:0] MASK_FORMAT = 8'h27;
    localparam logic [7:0] MASK_PHASE_FLAG = 8'h07;

    // Reset values
    localparam logic [7:0] RST_ATT = 8'hff;
    localparam logic [7:0] RST_MUTE_RATE = 8'h00;
    localparam logic [7:0] RST_CHAN_DEEMPH = 8'h00;
    localparam logic [7:0] RST_FORMAT = 8'h05;
    localparam logic [7:0] RST_PHASE_FLAG = 8'h00;

    // Attenuation: codes at or below this one are infinite attenuation
    localparam logic [7:0] ATT_MUTE_CODE = 8'h80;

    // Ramp pacing: one step per this many sample periods
    localparam int STEP_SAMPLES = 8;
    localparam logic [2:0] STEP_LAST = 3'(STEP_SAMPLES - 1);

    // Oversampling ratios
    localparam logic [7:0] OVS_32 = 8'h20;
    localparam logic [7:0] OVS_64 = 8'h40;
    localparam logic [7:0] OVS_128 = 8'h80;

    // Audio data format codes
    typedef enum logic [2:0] {
        FMT_RJ24 = 3'h0,
        FMT_RJ20 = 3'h1,
        FMT_RJ18 = 3'h2,
        FMT_RJ16 = 3'h3,
        FMT_I2S = 3'h4,
        FMT_LJ = 3'h5,
        FMT_RSV6 = 3'h6,
        FMT_RSV7 = 3'h7
    } adm_format_t;

    // De-emphasis sample rate codes
    typedef enum logic [1:0] {
        DEEMPH_44K1 = 2'h0,
        DEEMPH_48K = 2'h1,
        DEEMPH_32K = 2'h2,
        DEEMPH_RSV = 2'h3
    } adm_deemph_t;

    // Decoded configuration handed to the datapath
    typedef struct packed {
        logic left_soft_mute;
        logic right_soft_mute;
        logic ovs_select;
        logic left_output_disable;
        logic right_output_disable;
        logic deemph_enable;
        adm_deemph_t deemph_rate_select;
        adm_format_t audio_format_select;
        logic rolloff_select;
        logic output_invert;
        logic flag_polarity;
        logic flag_combine_select;
    } adm_cfg_t;

endpackage

/* rtl/adm_mode_ctrl.sv */
// Mode control register bank with soft mute ramps and zero flags
`timescale 1ns/1ps

// Summary of operation
// - Mute set: attenuator steps down 0.5 dB per 8 samples to infinite.
// - Mute cleared: attenuator steps up per 8 samples to programmed level.
// - Bit 0 mutes left, bit 1 right; both reset 0, 0 is normal.
// - Fast system clocks: oversampling select gives 64x at 0, 128x at 1.
// - 128 or 192 fS clocks: oversampling select gives 32x or 64x.
// - Writing soft reinit 1 returns all registers to defaults.
// - Output disable 1 holds that channel at bipolar zero.
// - Output disable 0 plays data; bit 0 left, bit 1 right.
// - De-emphasis applies only while its enable bit is 1.
// - Rate field: 00 44.1k, 01 48k, 10 32k, 11 reserved.
// - Format 000..011: right-justified 24, 20, 18, 16 bit.
// - Format 100 I2S, 101 left-justified default, 110/111 reserved.
// - Rolloff select: 0 sharp, 1 slow.
// - Output invert: 0 normal phase, 1 inverted.
// - Flag polarity: 0 high on zero, 1 low on zero.
// - Combine select 0 separate flags, 1 common flag on one pin.
// - Word: bit 15 zero, bits 14:8 index 10h-16h, bits 7:0 data.
// - Attenuation codes 0 to 128 mean infinite attenuation.
module adm_mode_ctrl
    import adm_pkg::*;
#(
    parameter int ZERO_SAMPLES = 1024
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Control word port
    input wire logic i_word_valid,
    input wire logic [15:0] i_word,
    // Sample clock pin and audio data status
    input wire logic i_lrck,
    input wire logic i_left_data_zero,
    input wire logic i_right_data_zero,
    input wire logic i_clk_ratio_low,
    // Configuration and datapath controls
    output adm_cfg_t o_cfg,
    output logic [7:0] o_left_level,
    output logic [7:0] o_right_level,
    output logic [1:0] o_ramp_busy,
    output logic [7:0] o_ovs_ratio,
    // Zero flag pins
    output logic o_flag_pin_a,
    output logic o_flag_pin_b
);

    localparam int ZW = 16;
    localparam logic [ZW-1:0] ZERO_LIMIT = ZW'(ZERO_SAMPLES);

    // Register storage
    logic [7:0] att_reg [2];
    logic [7:0] mute_rate_reset_ctrl;
    logic [7:0] channel_enable_deemph_ctrl;
    logic [7:0] format_filter_ctrl;
    logic [7:0] phase_flag_ctrl;
    logic [7:0] next_att_reg [2];
    logic [7:0] next_mute_rate_reset_ctrl;
    logic [7:0] next_channel_enable_deemph_ctrl;
    logic [7:0] next_format_filter_ctrl;
    logic [7:0] next_phase_flag_ctrl;
    logic reinit_req;
    logic next_reinit_req;
    logic init;

    // Word decode
    logic [6:0] word_idx;
    logic [7:0] word_data;
    logic word_ok;

    assign word_idx = i_word[IDX_MSB:IDX_LSB];
    assign word_data = i_word[DATA_MSB:0];
    assign word_ok = i_word_valid && !i_word[WORD_ZERO_BIT];

    // Power-on or soft reinit both start from defaults
    assign init = !i_rst_n || reinit_req;

    // Register write decode; unknown indices fall through untouched
    always_comb begin
        next_att_reg = att_reg;
        next_mute_rate_reset_ctrl = mute_rate_reset_ctrl;
        next_channel_enable_deemph_ctrl = channel_enable_deemph_ctrl;
        next_format_filter_ctrl = format_filter_ctrl;
        next_phase_flag_ctrl = phase_flag_ctrl;
        next_reinit_req = 1'b0;
        if (word_ok) begin
            unique case (word_idx)
                IDX_ATT_LEFT: next_att_reg[0] = word_data;
                IDX_ATT_RIGHT: next_att_reg[1] = word_data;
                IDX_MUTE_RATE: begin
                    // Reinit bit is a command, it never reads back as 1
                    next_mute_rate_reset_ctrl = word_data & MASK_MUTE_RATE;
                    next_reinit_req = word_data[POS_SOFT_REINIT];
                end
                IDX_CHAN_DEEMPH: begin
                    next_channel_enable_deemph_ctrl =
                        word_data & MASK_CHAN_DEEMPH;
                end
                IDX_FORMAT: next_format_filter_ctrl = word_data & MASK_FORMAT;
                IDX_PHASE_FLAG: begin
                    next_phase_flag_ctrl = word_data & MASK_PHASE_FLAG;
                end
                default: ; // Undefined index: ignored
            endcase
        end
    end

    // Register bank flops
    always_ff @(posedge i_mclk) begin
        if (init) begin
            att_reg[0] <= RST_ATT;
            att_reg[1] <= RST_ATT;
            mute_rate_reset_ctrl <= RST_MUTE_RATE;
            channel_enable_deemph_ctrl <= RST_CHAN_DEEMPH;
            format_filter_ctrl <= RST_FORMAT;
            phase_flag_ctrl <= RST_PHASE_FLAG;
            reinit_req <= 1'b0;
        end else begin
            att_reg <= next_att_reg;
            mute_rate_reset_ctrl <= next_mute_rate_reset_ctrl;
            channel_enable_deemph_ctrl <= next_channel_enable_deemph_ctrl;
            format_filter_ctrl <= next_format_filter_ctrl;
            phase_flag_ctrl <= next_phase_flag_ctrl;
            reinit_req <= next_reinit_req;
        end
    end

    // Field breakout to the datapath
    always_comb begin
        o_cfg.left_soft_mute = mute_rate_reset_ctrl[POS_LEFT_MUTE];
        o_cfg.right_soft_mute = mute_rate_reset_ctrl[POS_RIGHT_MUTE];
        o_cfg.ovs_select = mute_rate_reset_ctrl[POS_OVS];
        o_cfg.left_output_disable =
            channel_enable_deemph_ctrl[POS_LEFT_DIS];
        o_cfg.right_output_disable =
            channel_enable_deemph_ctrl[POS_RIGHT_DIS];
        o_cfg.deemph_enable =
            channel_enable_deemph_ctrl[POS_DEEMPH_EN];
        o_cfg.deemph_rate_select = adm_deemph_t'(
            channel_enable_deemph_ctrl[POS_DEEMPH_RATE +: 2]);
        o_cfg.audio_format_select = adm_format_t'(
            format_filter_ctrl[POS_FORMAT +: 3]);
        o_cfg.rolloff_select = format_filter_ctrl[POS_ROLLOFF];
        o_cfg.output_invert = phase_flag_ctrl[POS_INVERT];
        o_cfg.flag_polarity = phase_flag_ctrl[POS_FLAG_POL];
        o_cfg.flag_combine_select = phase_flag_ctrl[POS_FLAG_COMB];
    end

    // Oversampling ratio depends on the detected system clock ratio
    always_comb begin
        if (i_clk_ratio_low) begin
            o_ovs_ratio = o_cfg.ovs_select ? OVS_64 : OVS_32;
        end else begin
            o_ovs_ratio = o_cfg.ovs_select ? OVS_128 : OVS_64;
        end
    end

    // Sample clock pin synchroniser; stage one feeds only stage two
    logic [2:0] lr_sync;
    logic lr_stable;
    logic next_lr_stable;
    logic sample_tick;

    // A level counts once stages two and three agree
    always_comb begin
        next_lr_stable = lr_stable;
        if (lr_sync[1] == lr_sync[2]) begin
            next_lr_stable = lr_sync[2];
        end
    end

    assign sample_tick = next_lr_stable && !lr_stable;

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            lr_sync <= 3'h0;
            lr_stable <= 1'b0;
        end else begin
            lr_sync <= {lr_sync[1:0], i_lrck};
            lr_stable <= next_lr_stable;
        end
    end

    // Ramp pacing: a step enable every eighth sample period
    logic [2:0] step_cnt;
    logic [2:0] next_step_cnt;
    logic step_en;

    assign step_en = sample_tick && (step_cnt == STEP_LAST);

    always_comb begin
        next_step_cnt = step_cnt;
        if (sample_tick) begin
            next_step_cnt = step_cnt + 3'h1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (init) begin
            step_cnt <= 3'h0;
        end else begin
            step_cnt <= next_step_cnt;
        end
    end

    // Per-channel attenuator ramp and zero detector
    logic [1:0] mute_bit;
    logic [1:0] data_zero;
    logic [7:0] level [2];
    logic [1:0] zero_det;

    assign mute_bit = {o_cfg.right_soft_mute, o_cfg.left_soft_mute};
    assign data_zero = {i_right_data_zero, i_left_data_zero};

    generate
        for (genvar ch = 0; ch < 2; ch++) begin : g_chan
            logic [7:0] target;
            logic [7:0] next_level;
            logic [ZW-1:0] zero_cnt;
            logic [ZW-1:0] next_zero_cnt;

            // Low codes all mean mute, so the ramp floor is the mute code
            always_comb begin
                if (mute_bit[ch] || att_reg[ch] <= ATT_MUTE_CODE) begin
                    target = ATT_MUTE_CODE;
                end else begin
                    target = att_reg[ch];
                end
                next_level = level[ch];
                if (step_en && level[ch] > target) begin
                    next_level = level[ch] - 8'h01;
                end else if (step_en && level[ch] < target) begin
                    next_level = level[ch] + 8'h01;
                end
            end

            // Run of all-zero samples, saturating at the limit
            always_comb begin
                next_zero_cnt = zero_cnt;
                if (sample_tick) begin
                    if (!data_zero[ch]) begin
                        next_zero_cnt = '0;
                    end else if (zero_cnt != ZERO_LIMIT) begin
                        next_zero_cnt = zero_cnt + ZW'(1);
                    end
                end
            end

            always_ff @(posedge i_mclk) begin
                if (init) begin
                    level[ch] <= RST_ATT;
                    zero_cnt <= '0;
                end else begin
                    level[ch] <= next_level;
                    zero_cnt <= next_zero_cnt;
                end
            end

            assign zero_det[ch] = (zero_cnt == ZERO_LIMIT);
            assign o_ramp_busy[ch] = (level[ch] != target);
        end
    endgenerate

    assign o_left_level = level[0];
    assign o_right_level = level[1];

    // Flag pins: pin a carries right or common, pin b left or idle
    logic flag_a;
    logic flag_b;
    logic next_flag_a;
    logic next_flag_b;

    // The unassigned pin rests at the inactive level rather than floating
    always_comb begin
        if (o_cfg.flag_combine_select) begin
            next_flag_a = &zero_det;
            next_flag_b = 1'b0;
        end else begin
            next_flag_a = zero_det[1];
            next_flag_b = zero_det[0];
        end
        next_flag_a = next_flag_a ^ o_cfg.flag_polarity;
        next_flag_b = next_flag_b ^ o_cfg.flag_polarity;
    end

    always_ff @(posedge i_mclk) begin
        if (init) begin
            flag_a <= 1'b0;
            flag_b <= 1'b0;
        end else begin
            flag_a <= next_flag_a;
            flag_b <= next_flag_b;
        end
    end

    assign o_flag_pin_a = flag_a;
    assign o_flag_pin_b = flag_b;

endmodule

/* bench/adm_mode_ctrl_assertions.sv */
// Assertion checker for the mode control register bank
`timescale 1ns/1ps
module adm_chk
    import adm_pkg::*;
#(
    parameter int ZERO_SAMPLES = 1024
) (
    // Inputs of the bank
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_word_valid,
    input wire logic [15:0] i_word,
    input wire logic i_lrck,
    input wire logic i_left_data_zero,
    input wire logic i_right_data_zero,
    input wire logic i_clk_ratio_low,
    // Outputs of the bank
    input wire adm_cfg_t o_cfg,
    input wire logic [7:0] o_left_level,
    input wire logic [7:0] o_right_level,
    input wire logic [1:0] o_ramp_busy,
    input wire logic [7:0] o_ovs_ratio,
    input wire logic o_flag_pin_a,
    input wire logic o_flag_pin_b
);
    // Accepted words; a reinit word wipes the word that follows it
    logic wr_ok;
    logic reinit_w;
    logic [6:0] idx;
    assign idx = i_word[14:8];
    assign wr_ok = i_word_valid && !i_word[15];
    assign reinit_w = wr_ok && idx == IDX_MUTE_RATE && i_word[7];
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    property p_ovs_fast;
        !i_clk_ratio_low |->
            o_ovs_ratio == (o_cfg.ovs_select ? OVS_128 : OVS_64);
    endproperty
    a_ovs_fast: assert property (p_ovs_fast)
        else $error("ovs ratio wrong at fast clock");
    property p_ovs_slow;
        i_clk_ratio_low |->
            o_ovs_ratio == (o_cfg.ovs_select ? OVS_64 : OVS_32);
    endproperty
    a_ovs_slow: assert property (p_ovs_slow)
        else $error("ovs ratio wrong at slow clock");
    property p_fmt;
        wr_ok && idx == IDX_FORMAT && !$past(reinit_w) |=>
            {o_cfg.audio_format_select, o_cfg.rolloff_select}
            == $past({i_word[2:0], i_word[5]});
    endproperty
    a_fmt: assert property (p_fmt)
        else $error("format write not applied");
    property p_chan;
        wr_ok && idx == IDX_CHAN_DEEMPH && !$past(reinit_w) |=>
            {o_cfg.left_output_disable, o_cfg.right_output_disable,
            o_cfg.deemph_enable, o_cfg.deemph_rate_select}
            == $past({i_word[0], i_word[1], i_word[4], i_word[6:5]});
    endproperty
    a_chan: assert property (p_chan)
        else $error("channel write not applied");
    property p_phase;
        wr_ok && idx == IDX_PHASE_FLAG && !$past(reinit_w) |=>
            {o_cfg.output_invert, o_cfg.flag_polarity,
            o_cfg.flag_combine_select}
            == $past({i_word[0], i_word[1], i_word[2]});
    endproperty
    a_phase: assert property (p_phase)
        else $error("phase write not applied");
    property p_mute;
        wr_ok && idx == IDX_MUTE_RATE && !i_word[7] && !$past(reinit_w) |=>
            {o_cfg.left_soft_mute, o_cfg.right_soft_mute, o_cfg.ovs_select}
            == $past({i_word[0], i_word[1], i_word[6]});
    endproperty
    a_mute: assert property (p_mute)
        else $error("mute write not applied");
    property p_reinit;
        reinit_w |=> ##1 o_cfg == adm_cfg_t'(15'h0050)
            && o_left_level == RST_ATT && o_right_level == RST_ATT;
    endproperty
    a_reinit: assert property (p_reinit)
        else $error("soft reinit left state behind");
    property p_ignore;
        i_word_valid && !$past(reinit_w) && (i_word[15]
            || !(idx inside {[7'h10:7'h14], 7'h16})) |=> $stable(o_cfg);
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("refused word changed a register");
    property p_step;
        $changed(o_left_level) && !$past(reinit_w) && !$past(reinit_w, 2) |->
            o_left_level - $past(o_left_level) == 8'h01
            || $past(o_left_level) - o_left_level == 8'h01;
    endproperty
    a_step: assert property (p_step)
        else $error("level moved more than one step");
    property p_floor;
        o_cfg.left_soft_mute |-> o_left_level >= ATT_MUTE_CODE
            && o_ramp_busy[0] == (o_left_level != ATT_MUTE_CODE);
    endproperty
    a_floor: assert property (p_floor)
        else $error("muted ramp does not end at mute code");
    property p_spare_pin;
        (o_cfg.flag_combine_select && $stable(o_cfg)) [*2] |->
            o_flag_pin_b == o_cfg.flag_polarity;
    endproperty
    a_spare_pin: assert property (p_spare_pin)
        else $error("unassigned flag pin not inactive");
endmodule

bind adm_mode_ctrl adm_chk #(.ZERO_SAMPLES(ZERO_SAMPLES)) adm_chk_inst (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_word_valid(i_word_valid),
    .i_word(i_word), .i_lrck(i_lrck), .i_left_data_zero(i_left_data_zero),
    .i_right_data_zero(i_right_data_zero), .i_clk_ratio_low(i_clk_ratio_low),
    .o_cfg(o_cfg), .o_left_level(o_left_level), .o_right_level(o_right_level),
    .o_ramp_busy(o_ramp_busy), .o_ovs_ratio(o_ovs_ratio),
    .o_flag_pin_a(o_flag_pin_a), .o_flag_pin_b(o_flag_pin_b));

/* bench/adm_host_model.sv */
// Host model: hands control words to the bank's word port
`timescale 1ns/1ps
module adm_host_model (
    // Clock
    input wire logic i_mclk,
    // Control word port
    output logic o_word_valid,
    output logic [15:0] o_word
);
    initial begin
        o_word_valid = 1'b0;
        o_word = 16'h0000;
    end
    // Driven after a falling edge, held across the next rising edge
    task automatic send(input logic [6:0] idx, input logic [7:0] d,
        input logic bad);
        @(negedge i_mclk);
        o_word_valid <= 1'b1;
        o_word <= {bad, idx, d};
    endtask
    // Released lines show the inverse so stale data never looks fresh
    task automatic idle();
        @(negedge i_mclk);
        o_word_valid <= 1'b0;
        o_word <= ~o_word;
    endtask
endmodule

/* bench/test_audio_dac_mode_control.sv */
// Self-checking bench for the mode control register bank
`timescale 1ns/1ps
module test_audio_dac_mode_control;
    import adm_pkg::*;
    logic i_mclk;
    logic i_rst_n;
    logic i_lrck;
    logic lz;
    logic rz;
    logic ratio_low;
    logic word_valid;
    logic [15:0] word;
    adm_cfg_t cfg;
    logic [7:0] ll;
    logic [7:0] rl;
    logic [1:0] busy;
    logic [7:0] ovs;
    logic pin_a;
    logic pin_b;
    logic [31:0] r;
    logic [6:0] ix;
    logic [6:0] tbl[9] = '{7'h10, 7'h11, 7'h12, 7'h13, 7'h14, 7'h16,
        7'h15, 7'h17, 7'h00};
    int fail_count;
    int checked;
    int seed;
    int regs[7];

    adm_mode_ctrl #(.ZERO_SAMPLES(4)) adm_mode_ctrl_inst (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_word_valid(word_valid),
        .i_word(word), .i_lrck(i_lrck), .i_left_data_zero(lz),
        .i_right_data_zero(rz), .i_clk_ratio_low(ratio_low), .o_cfg(cfg),
        .o_left_level(ll), .o_right_level(rl), .o_ramp_busy(busy),
        .o_ovs_ratio(ovs), .o_flag_pin_a(pin_a), .o_flag_pin_b(pin_b));
    adm_host_model adm_host_model_inst (.i_mclk(i_mclk),
        .o_word_valid(word_valid), .o_word(word));

    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    // Sample clock of 16 system clocks, toggled on falling edges
    initial begin
        i_lrck = 1'b0;
        forever #80 i_lrck = ~i_lrck;
    end

    task automatic check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("Counts: %0d compared, %0d wrong", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Reference register image; reserved bits never stick
    task automatic wr(input logic [6:0] idx, input logic [7:0] d,
        input logic bad);
        logic [7:0] m;
        m = idx == 7'h12 ? 8'h43 : idx == 7'h13 ? 8'h73 : idx == 7'h14 ? 8'h27
            : idx == 7'h16 ? 8'h07 : 8'hff;
        // Host keeps reserved positions at zero
        adm_host_model_inst.send(idx, d & m, bad);
        adm_host_model_inst.idle();
        if (!bad && (idx inside {[7'h10:7'h14], 7'h16})) begin
            regs[idx - 7'h10] = int'(d & m);
        end
    endtask
    function automatic logic [14:0] exp_cfg();
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] c;
        logic [7:0] e;
        a = 8'(regs[2]);
        b = 8'(regs[3]);
        c = 8'(regs[4]);
        e = 8'(regs[6]);
        return {a[0], a[1], a[6], b[0], b[1], b[4], b[6:5], c[2:0], c[5],
            e[0], e[1], e[2]};
    endfunction
    // Waits out a ramp, counting level moves on the left channel
    task automatic ramp(input logic [7:0] el, input int steps, input int lo,
        input int hi);
        int moves;
        int t;
        logic [7:0] prev;
        moves = 0;
        prev = ll;
        for (t = 0; t < hi && busy !== 2'b00; t++) begin
            @(negedge i_mclk);
            moves += int'(ll !== prev);
            prev = ll;
        end
        check("ramp_levels", {ll, rl}, {el, 8'hff});
        check("ramp_moves", moves, steps);
        check("ramp_time_ok", t >= lo && t < hi, 1);
        if (t >= hi) give_verdict();
    endtask
    task automatic flags(input logic ea, input logic eb);
        int t;
        for (t = 0; t < 400 && {pin_a, pin_b} !== {ea, eb}; t++) begin
            @(negedge i_mclk);
        end
        check("flag_pins", {pin_a, pin_b}, {ea, eb});
        if (t == 400) give_verdict();
    endtask

    initial begin
        seed = 40;
        fail_count = 0;
        checked = 0;
        i_rst_n = 1'b0;
        lz = 1'b0;
        rz = 1'b0;
        ratio_low = 1'b0;
        regs = '{255, 255, 0, 0, 5, 0, 0};
        repeat (20) @(negedge i_mclk);
        i_rst_n = 1'b1;
        check("cfg_reset", cfg, exp_cfg());
        check("level_reset", {ll, rl, ovs}, 24'hffff40);
        $display("TEST reset done");
        // Both clock ratio classes with both oversampling settings
        for (int k = 0; k < 4; k++) begin
            ratio_low = k[1];
            wr(7'h12, {1'b0, k[0], 6'h00}, 1'b0);
            check("ovs", ovs, k[1] ? 32 << k[0] : 64 << k[0]);
        end
        $display("TEST oversampling done");
        // Every format, rate and phase code, then random words and refusals
        for (int f = 0; f < 8; f++) begin
            wr(7'h14, {2'b00, f[0], 2'b00, f[2:0]}, 1'b0);
            check("cfg_fmt", cfg, exp_cfg());
            wr(7'h13, {1'b0, f[1:0], f[2], 2'b00, f[1:0]}, 1'b0);
            check("cfg_chan", cfg, exp_cfg());
            wr(7'h16, {5'h00, f[2:0]}, 1'b0);
            check("cfg_phase", cfg, exp_cfg());
        end
        for (int n = 0; n < 40; n++) begin
            r = $random(seed);
            ix = tbl[r[3:0] % 9];
            wr(ix, r[15:8] & (ix == 7'h12 ? 8'h7f : 8'hff), r[18:16] == 3'h0);
            check("cfg_rand", cfg, exp_cfg());
        end
        $display("TEST register writes done");
        // Reinit, with a word right behind it that must be lost
        adm_host_model_inst.send(7'h14, 8'h03, 1'b0);
        adm_host_model_inst.send(7'h12, 8'h80, 1'b0);
        adm_host_model_inst.send(7'h14, 8'h01, 1'b0);
        adm_host_model_inst.idle();
        regs = '{255, 255, 0, 0, 5, 0, 0};
        check("cfg_reinit", {cfg, ll, rl}, {exp_cfg(), 16'hffff});
        $display("TEST soft reinit done");
        // Ramp to a level, mute the left channel, then release it
        wr(7'h10, 8'h88, 1'b0);
        ramp(8'h88, 119, 0, 20000);
        wr(7'h12, 8'h01, 1'b0);
        ramp(8'h80, 8, 880, 1100);
        wr(7'h12, 8'h00, 1'b0);
        ramp(8'h88, 8, 880, 1100);
        $display("TEST soft mute done");
        // Zero flags: separate, inverted, then common
        lz = 1'b1;
        flags(1'b0, 1'b1);
        wr(7'h16, 8'h02, 1'b0);
        flags(1'b1, 1'b0);
        // Right detect first, so the common-mode change is seen on the pins
        rz = 1'b1;
        flags(1'b0, 1'b0);
        wr(7'h16, 8'h04, 1'b0);
        flags(1'b1, 1'b0);
        lz = 1'b0;
        flags(1'b0, 1'b0);
        $display("TEST zero flags done");
        give_verdict();
    end
endmodule
